/* File: rtl/mvd_decode.sv */
// decode and execute stage for the general move, the address-register move and the quick 3-bit move
// assumes the operand has already been fetched into srcData in the cycle opValid is high
//
// Operation
// - top bits 00 is move; size 01/11/10
// - move destination field and allowed destination modes
// - all twelve source modes accepted
// - extended sources refuse indexed or absolute destinations
// - immediate to d16 only byte/word, newest core
// - move sets N Z, clears V C
// - address move: destination mode 001, word/long
// - address move leaves flags untouched
// - address move accepts all twelve sources
// - quick move: 1010 and 101 marker bits
// - quick move writes full 32-bit value
// - quick field zero means minus one
// - quick move refuses immediate and PC destinations
// - quick move sets N Z, clears V C
`timescale 1ns/1ps
module mvd_decode
  import mvd_pkg::*;
#(
  parameter int IMM_D16_SUPPORTED = 1
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic opValid,
  input wire logic [15:0] opWord,
  input wire logic [31:0] srcData,
  input wire logic [4:0] flagsIn,
  output logic resValid,
  output mvd_kind_t resKind,
  output logic resIllegal,
  output logic [1:0] resSize,
  output logic [2:0] resDstMode,
  output logic [2:0] resDstReg,
  output logic [31:0] resData,
  output logic [4:0] resFlags,
  output logic resFlagsWrite
);
  generate
    if ((IMM_D16_SUPPORTED != 0) && (IMM_D16_SUPPORTED != 1))
    begin : g_bad_param
      $error("IMM_D16_SUPPORTED must be 0 or 1");
    end
  endgenerate

  logic [1:0] sizeCode;
  logic [2:0] dstReg;
  logic [2:0] dstMode;
  logic [2:0] srcMode;
  logic [2:0] srcReg;
  logic srcValid, srcExt, srcImm;
  logic dstValid, dstAreg, dstD16, dstHeavy, dstImm, dstPcRel;
  logic qValid, qImm, qPcRel;

  // field split of the operation word
  assign sizeCode = opWord[OP_SIZE_HI:OP_SIZE_LO];
  assign dstReg = opWord[11:9];
  assign dstMode = opWord[8:6];
  assign srcMode = opWord[5:3];
  assign srcReg = opWord[2:0];

  // classes that a field never needs are left open rather than wired to unread nets
  mvd_ea_class u_src (
    .mode(srcMode), .regNum(srcReg), .eaValid(srcValid), .eaIsAreg(), .eaIsD16(),
    .eaNeedsExt(srcExt), .eaHeavyDst(), .eaIsImm(srcImm), .eaIsPcRel()
  );
  mvd_ea_class u_dst (
    .mode(dstMode), .regNum(dstReg), .eaValid(dstValid), .eaIsAreg(dstAreg), .eaIsD16(dstD16),
    .eaNeedsExt(), .eaHeavyDst(dstHeavy), .eaIsImm(dstImm), .eaIsPcRel(dstPcRel)
  );
  // the quick move keeps its destination in the low six bits
  mvd_ea_class u_qdst (
    .mode(srcMode), .regNum(srcReg), .eaValid(qValid), .eaIsAreg(), .eaIsD16(),
    .eaNeedsExt(), .eaHeavyDst(), .eaIsImm(qImm), .eaIsPcRel(qPcRel)
  );

  // instruction recognition
  logic isMoveGroup, isAddrMove, isMove, isQuick;
  assign isMoveGroup = (opWord[OP_TOP_HI:OP_TOP_LO] == MOVE_TOP) && (sizeCode != SIZE_NONE);
  assign isAddrMove = isMoveGroup && dstAreg;
  assign isMove = isMoveGroup && !dstAreg;
  assign isQuick = (opWord[15:12] == QUICK_TOP) && (opWord[8:6] == QUICK_MARK);

  // legality checks
  logic dstBad, pairBad, immD16Bad, moveIllegal, addrIllegal, quickIllegal;
  assign dstBad = !dstValid || dstImm || dstPcRel;
  assign pairBad = srcExt && dstHeavy;
  // immediate into d16 is a newer addition; older cores refuse it at every size
  assign immD16Bad = srcImm && dstD16 && ((IMM_D16_SUPPORTED == 0) || (sizeCode == SIZE_LONG));
  assign moveIllegal = !srcValid || dstBad || pairBad || immD16Bad;
  assign addrIllegal = !srcValid || (sizeCode == SIZE_BYTE);
  assign quickIllegal = !qValid || qImm || qPcRel;

  // data path: size the moved value
  logic [31:0] moveData, addrData, quickData, nextData;
  assign moveData = (sizeCode == SIZE_BYTE) ? {24'h000000, srcData[7:0]} :
                    (sizeCode == SIZE_WORD) ? {16'h0000, srcData[15:0]} : srcData;
  assign addrData = (sizeCode == SIZE_WORD) ? {{16{srcData[15]}}, srcData[15:0]} : srcData;
  // zero in the field stands for minus one, so the value is never zero
  assign quickData = (opWord[11:9] == 3'h0) ? QUICK_MINUS_ONE : {29'h0, opWord[11:9]};

  // flags of the sized result
  logic moveNeg, moveZero;
  assign moveNeg = (sizeCode == SIZE_BYTE) ? srcData[7] : (sizeCode == SIZE_WORD) ? srcData[15] : srcData[31];
  assign moveZero = (moveData == 32'h0000_0000);

  // next state of the result stage
  mvd_kind_t kind_nxt;
  logic illegal_nxt, flagsWrite_nxt;
  logic [4:0] flags_nxt, flagsNew;
  logic [2:0] dstMode_nxt, dstReg_nxt;
  assign kind_nxt = isAddrMove ? MVD_KIND_ADDR : isMove ? MVD_KIND_MOVE :
                    isQuick ? MVD_KIND_QUICK : MVD_KIND_NONE;
  assign illegal_nxt = isAddrMove ? addrIllegal : isMove ? moveIllegal : isQuick ? quickIllegal : 1'b0;
  assign nextData = isAddrMove ? addrData : isMove ? moveData : isQuick ? quickData : DATA_RESET;
  assign flagsWrite_nxt = (isMove || isQuick) && !illegal_nxt;
  // X passes unchanged in both flag-setting forms
  assign flagsNew = isMove ? {flagsIn[CC_X], moveNeg, moveZero, 2'b00} :
                    {flagsIn[CC_X], quickData[31], 1'b0, 2'b00};
  // refused and flag-neutral instructions hand the old flags through, so no stale value is offered
  assign flags_nxt = flagsWrite_nxt ? flagsNew : flagsIn;
  assign dstMode_nxt = isQuick ? srcMode : dstMode;
  assign dstReg_nxt = isQuick ? srcReg : dstReg;

  // result stage register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      resValid <= 1'b0;
      resKind <= MVD_KIND_NONE;
      resIllegal <= 1'b0;
      resSize <= SIZE_NONE;
      resDstMode <= 3'h0;
      resDstReg <= 3'h0;
      resData <= DATA_RESET;
      resFlags <= FLAGS_RESET;
      resFlagsWrite <= 1'b0;
    end
    else
    begin
      resValid <= opValid;
      resKind <= opValid ? kind_nxt : MVD_KIND_NONE;
      resIllegal <= opValid && illegal_nxt;
      resSize <= isQuick ? SIZE_LONG : sizeCode;
      resDstMode <= dstMode_nxt;
      resDstReg <= dstReg_nxt;
      resData <= nextData;
      resFlags <= flags_nxt;
      resFlagsWrite <= opValid && flagsWrite_nxt;
    end
  end

  // checks on the result stage
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_move_size;
    opValid && isMove && (sizeCode == SIZE_BYTE) |=> resData[31:8] == 24'h000000;
  endproperty
  a_move_size: assert property (p_move_size) else $error("byte move kept upper bits");

  property p_dst_reject;
    opValid && isMove && (dstImm || dstPcRel) |=> resIllegal;
  endproperty
  a_dst_reject: assert property (p_dst_reject) else $error("bad move destination accepted");

  property p_pair_reject;
    opValid && isMove && srcExt && dstHeavy |=> resIllegal && !resFlagsWrite;
  endproperty
  a_pair_reject: assert property (p_pair_reject) else $error("extended source pairing accepted");

  property p_imm_d16_long;
    opValid && isMove && srcImm && dstD16 && (sizeCode == SIZE_LONG) |=> resIllegal;
  endproperty
  a_imm_d16_long: assert property (p_imm_d16_long) else $error("long immediate to d16 accepted");

  property p_move_flags;
    opValid && isMove && !moveIllegal |=> resFlags[CC_V] == 1'b0 && resFlags[CC_C] == 1'b0 &&
      resFlags[CC_X] == $past(flagsIn[CC_X]) && resFlags[CC_Z] == (resData == 32'h0000_0000);
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move flags wrong");

  property p_addr_keep;
    opValid && isAddrMove |=> resFlags == $past(flagsIn) && !resFlagsWrite && resKind == MVD_KIND_ADDR;
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("address move touched flags");

  property p_addr_sext;
    opValid && isAddrMove && (sizeCode == SIZE_WORD) |=> resData[31:16] == {16{resData[15]}};
  endproperty
  a_addr_sext: assert property (p_addr_sext) else $error("word address move not sign-extended");

  property p_quick_minus;
    opValid && isQuick && (opWord[11:9] == 3'h0) |=> resData == 32'hFFFF_FFFF && resFlags[CC_N];
  endproperty
  a_quick_minus: assert property (p_quick_minus) else $error("quick zero field not minus one");

  property p_quick_nonzero;
    resValid && resKind == MVD_KIND_QUICK |-> resData != 32'h0000_0000 && !resFlags[CC_Z];
  endproperty
  a_quick_nonzero: assert property (p_quick_nonzero) else $error("quick result zero");

  property p_quick_dst;
    opValid && isQuick && (qImm || qPcRel) |=> resIllegal;
  endproperty
  a_quick_dst: assert property (p_quick_dst) else $error("quick bad destination accepted");

  property p_quick_flags;
    opValid && isQuick && !quickIllegal |=> resFlagsWrite && resFlags[CC_N] == resData[31] &&
      resFlags[CC_V:CC_C] == 2'h0;
  endproperty
  a_quick_flags: assert property (p_quick_flags) else $error("quick flags wrong");

  // a refused instruction must neither commit nor alter the offered flags
  property p_illegal_keep;
    opValid && illegal_nxt |=> resIllegal && !resFlagsWrite && resFlags == $past(flagsIn);
  endproperty
  a_illegal_keep: assert property (p_illegal_keep) else $error("refused instruction changed flags");

  property p_result_idle;
    !opValid |=> !resValid && resKind == MVD_KIND_NONE && !resIllegal && !resFlagsWrite;
  endproperty
  a_result_idle: assert property (p_result_idle) else $error("result raised without an instruction");

  c_move_ok: cover property (opValid && isMove && !moveIllegal ##1 resValid);
  c_addr_word: cover property (opValid && isAddrMove && (sizeCode == SIZE_WORD));
  c_quick_ok: cover property (opValid && isQuick && !quickIllegal);
  c_imm_d16: cover property (opValid && isMove && srcImm && dstD16 && (sizeCode == SIZE_BYTE));
endmodule

/* File: rtl/mvd_pkg.sv */
// constants and types for the data-movement instruction decoder
// assumes a 16-bit operation word and a 32-bit operand path
package mvd_pkg;
  // operation word fields
  localparam int OP_TOP_HI = 15;
  localparam int OP_TOP_LO = 14;
  localparam int OP_SIZE_HI = 13;
  localparam int OP_SIZE_LO = 12;
  localparam logic [1:0] MOVE_TOP = 2'h0;
  localparam logic [3:0] QUICK_TOP = 4'hA;
  localparam logic [2:0] QUICK_MARK = 3'h5;
  // size codes of the general move
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h3;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_NONE = 2'h0;
  // addressing mode encodings
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_POST = 3'h3;
  localparam logic [2:0] MODE_PRE = 3'h4;
  localparam logic [2:0] MODE_D16 = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_W = 3'h0;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] EXT_PC_D16 = 3'h2;
  localparam logic [2:0] EXT_PC_IDX = 3'h3;
  localparam logic [2:0] EXT_IMM = 3'h4;
  // condition_code_flags bit positions
  localparam int CC_X = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  // values after reset, and the quick minus-one value
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [31:0] QUICK_MINUS_ONE = 32'hFFFF_FFFF;
  // decoded instruction kinds
  typedef enum logic [1:0] {
    MVD_KIND_NONE = 2'h0,
    MVD_KIND_MOVE = 2'h1,
    MVD_KIND_ADDR = 2'h3,
    MVD_KIND_QUICK = 2'h2
  } mvd_kind_t;
endpackage

/* File: rtl/mvd_ea_class.sv */
// classifier for one effective-address field (mode and register)
// purely combinational, used on the source and the destination field
`timescale 1ns/1ps
module mvd_ea_class
  import mvd_pkg::*;
(
  input wire logic [2:0] mode,
  input wire logic [2:0] regNum,
  output logic eaValid,
  output logic eaIsAreg,
  output logic eaIsD16,
  output logic eaNeedsExt,
  output logic eaHeavyDst,
  output logic eaIsImm,
  output logic eaIsPcRel
);
  logic isExtMode;
  // mode 111 selects one of five special forms by the register field
  assign isExtMode = (mode == MODE_EXT);
  assign eaIsImm = isExtMode && (regNum == EXT_IMM);
  assign eaIsPcRel = isExtMode && ((regNum == EXT_PC_D16) || (regNum == EXT_PC_IDX));
  assign eaValid = !isExtMode || (regNum <= EXT_IMM);
  assign eaIsAreg = (mode == MODE_AREG);
  assign eaIsD16 = (mode == MODE_D16);
  // forms that carry extension words of their own
  assign eaNeedsExt = (mode == MODE_D16) || (mode == MODE_IDX) || isExtMode;
  // destinations that cannot follow an extended source
  assign eaHeavyDst = (mode == MODE_IDX) || (isExtMode && ((regNum == EXT_ABS_W) || (regNum == EXT_ABS_L)));
endmodule

/* File: verification/test_move_instruction_decode.sv */
// self-checking bench for the data-movement decoder, one task per scenario
// assumes mvd_decode in its newest-core form as u_dut, an older-core copy beside it, one-cycle latency
`timescale 1ns/1ps
module test_move_instruction_decode
  import mvd_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic opValid = 1'b0;
  logic [15:0] opWord = 16'h0000;
  logic [31:0] srcData = 32'h0000_0000;
  logic [4:0] flagsIn = 5'h00;
  logic resValid, resIllegal, resFlagsWrite;
  mvd_kind_t resKind;
  logic [1:0] resSize;
  logic [2:0] resDstMode, resDstReg;
  logic [31:0] resData;
  logic [4:0] resFlags;
  logic oldIllegal, oldFlagsWrite;
  int mismatches = 0;
  int n_compared = 0;

  mvd_decode u_dut (.clk(clk), .srst(srst), .opValid(opValid), .opWord(opWord), .srcData(srcData),
    .flagsIn(flagsIn), .resValid(resValid), .resKind(resKind), .resIllegal(resIllegal), .resSize(resSize),
    .resDstMode(resDstMode), .resDstReg(resDstReg), .resData(resData), .resFlags(resFlags),
    .resFlagsWrite(resFlagsWrite));

  // an older core refuses an immediate into a displacement destination at every size
  mvd_decode #(.IMM_D16_SUPPORTED(0)) u_dut_old (.clk(clk), .srst(srst), .opValid(opValid), .opWord(opWord),
    .srcData(srcData), .flagsIn(flagsIn), .resValid(), .resKind(), .resIllegal(oldIllegal), .resSize(),
    .resDstMode(), .resDstReg(), .resData(), .resFlags(), .resFlagsWrite(oldFlagsWrite));

  // free-running 10 MHz clock
  always #50 clk = ~clk;

  // comparison helpers, one per kind of result
  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    mismatches++;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) fail(got, exp);
  endtask
  task automatic chkCc(input logic [4:0] got, input logic [4:0] exp);
    n_compared++;
    if (got !== exp) fail({27'h0, got}, {27'h0, exp});
  endtask
  // decode status: valid, kind, illegal, flag write
  task automatic chkDec(input logic ill, input logic wr, input mvd_kind_t k);
    n_compared++;
    if ({resValid, resKind, resIllegal, resFlagsWrite} !== {1'b1, k, ill, wr})
      fail({27'h0, resValid, resKind, resIllegal, resFlagsWrite}, {27'h0, 1'b1, k, ill, wr});
  endtask

  // one instruction: drive at a falling edge, result is settled one falling edge later
  task automatic exec(input logic [15:0] op, input logic [31:0] src, input logic [4:0] cc);
    @(negedge clk);
    opValid = 1'b1;
    opWord = op;
    srcData = src;
    flagsIn = cc;
    @(negedge clk);
    opValid = 1'b0;
  endtask

  // index to {mode, reg}: 0..6 plain modes, then extended regs 0..5 (5 is invalid)
  function automatic logic [5:0] eaOf(input int i);
    eaOf = (i < 7) ? {3'(i), 3'h3} : {MODE_EXT, 3'(i - 7)};
  endfunction

  task automatic tSizes;
    exec(16'h1200, 32'hFFFF_FF80, 5'h13);
    chkDec(1'b0, 1'b1, MVD_KIND_MOVE);
    chkData(resData, 32'h0000_0080);
    chkCc(resFlags, 5'h18);
    exec(16'h3200, 32'h1234_0000, 5'h0B);
    chkData({30'h0, resSize}, {30'h0, SIZE_WORD});
    chkCc(resFlags, 5'h04);
    exec(16'h2200, 32'hFFFF_FFFF, 5'h17);
    chkData(resData, 32'hFFFF_FFFF);
    chkCc(resFlags, 5'h18);
    exec(16'h0200, 32'h0000_0001, 5'h00);
    chkDec(1'b0, 1'b0, MVD_KIND_NONE);
  endtask

  // every destination with a register source; address-register direct is the other instruction
  task automatic tDest;
    logic [5:0] ea;
    logic ill;
    for (int i = 0; i < 13; i++)
    begin
      ea = eaOf(i);
      ill = (ea[5:3] == MODE_EXT) && (ea[2:0] > 3'h1);
      if (i != 1)
      begin
        exec({2'b00, SIZE_LONG, ea[2:0], ea[5:3], MODE_DREG, 3'h0}, 32'h1, 5'h00);
        chkDec(ill, !ill, MVD_KIND_MOVE);
        chkData({26'h0, resDstMode, resDstReg}, {26'h0, ea[5:3], ea[2:0]});
      end
    end
  endtask

  // every source against a plain, an indexed and an absolute-long destination
  task automatic tSrc;
    logic [5:0] ea;
    logic [5:0] dst [3] = '{{MODE_DREG, 3'h1}, {MODE_IDX, 3'h2}, {MODE_EXT, EXT_ABS_L}};
    logic ill;
    for (int j = 0; j < 3; j++)
      for (int i = 0; i < 13; i++)
      begin
        ea = eaOf(i);
        ill = (i == 12) || ((j > 0) && (ea[5:3] >= MODE_D16));
        exec({2'b00, SIZE_LONG, dst[j][2:0], dst[j][5:3], ea}, 32'h2, 5'h00);
        chkDec(ill, !ill, MVD_KIND_MOVE);
      end
  endtask

  // immediate into a displacement destination: byte and word only
  task automatic tImmD16;
    logic [1:0] sz [3] = '{SIZE_BYTE, SIZE_WORD, SIZE_LONG};
    for (int i = 0; i < 3; i++)
    begin
      exec({2'b00, sz[i], 3'h0, MODE_D16, MODE_EXT, EXT_IMM}, 32'h5, 5'h0F);
      chkDec(i == 2, i != 2, MVD_KIND_MOVE);
      if (i == 2) chkCc(resFlags, 5'h0F);
      chkData({30'h0, oldIllegal, oldFlagsWrite}, 32'h0000_0002);
    end
  endtask

  task automatic tAddr;
    exec({2'b00, SIZE_WORD, 3'h4, MODE_AREG, MODE_DREG, 3'h0}, 32'h1234_8001, 5'h0A);
    chkDec(1'b0, 1'b0, MVD_KIND_ADDR);
    chkData(resData, 32'hFFFF_8001);
    chkCc(resFlags, 5'h0A);
    chkData({26'h0, resDstMode, resDstReg}, 32'h0000_000C);
    exec({2'b00, SIZE_LONG, 3'h4, MODE_AREG, MODE_DREG, 3'h0}, 32'h0000_8001, 5'h15);
    chkData(resData, 32'h0000_8001);
    exec({2'b00, SIZE_BYTE, 3'h4, MODE_AREG, MODE_DREG, 3'h0}, 32'h1, 5'h00);
    chkDec(1'b1, 1'b0, MVD_KIND_ADDR);
    for (int i = 0; i < 12; i++)
    begin
      exec({2'b00, SIZE_LONG, 3'h2, MODE_AREG, eaOf(i)}, 32'h0, 5'h1F);
      chkDec(1'b0, 1'b0, MVD_KIND_ADDR);
      chkCc(resFlags, 5'h1F);
    end
  endtask

  // reset in mid-run drops an instruction presented with it
  task automatic tReset;
    @(negedge clk);
    opValid = 1'b1;
    opWord = 16'hA140;
    srst = 1'b1;
    @(negedge clk);
    chkData({31'h0, resValid}, 32'h0000_0000);
    chkData(resData, DATA_RESET);
    chkCc(resFlags, FLAGS_RESET);
    srst = 1'b0;
    opValid = 1'b0;
  endtask

  // every data field, then every destination
  task automatic tQuick;
    logic [5:0] ea;
    logic ill;
    for (int f = 0; f < 8; f++)
    begin
      exec({QUICK_TOP, 3'(f), QUICK_MARK, MODE_DREG, 3'h2}, 32'h5555_AAAA, 5'h1F);
      chkDec(1'b0, 1'b1, MVD_KIND_QUICK);
      chkData(resData, (f == 0) ? 32'hFFFF_FFFF : 32'(f));
      chkCc(resFlags, {1'b1, f == 0, 3'h0});
    end
    for (int i = 0; i < 13; i++)
    begin
      ea = eaOf(i);
      ill = (ea[5:3] == MODE_EXT) && (ea[2:0] > 3'h1);
      exec({QUICK_TOP, 3'h7, QUICK_MARK, ea}, 32'h0, 5'h00);
      chkDec(ill, !ill, MVD_KIND_QUICK);
      chkData({26'h0, resDstMode, resDstReg}, {26'h0, ea});
    end
  endtask

  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence: ten cycles of reset, then the scenarios
  initial
  begin
    repeat (10) @(negedge clk);
    chkData(resData, DATA_RESET);
    chkCc(resFlags, FLAGS_RESET);
    srst = 1'b0;
    tSizes();
    tDest();
    tSrc();
    tImmD16();
    tAddr();
    tReset();
    tQuick();
    end_sim();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial
  begin
    #500000;
    mismatches++;
    end_sim();
  end
endmodule
